// file: inc/csss_pkg.sv
// package: constants and types of the clock source and start-up selector
package csss_pkg;
    // fuse polarity: 1 = unprogrammed, 0 = programmed
    localparam logic FUSE_PROGRAMMED = 1'h0;
    localparam logic FUSE_UNPROGRAMMED = 1'h1;
    // factory fuse image
    localparam logic [3:0] CLKSRC_DEFAULT = 4'h1;
    localparam logic [1:0] STARTUP_DEFAULT = 2'h2;
    localparam logic SWING_DEFAULT = 1'h1;
    // clock-source code boundaries
    localparam logic [3:0] CODE_XTAL_LOW = 4'hA;
    localparam logic [3:0] CODE_LFXTAL = 4'h9;
    localparam logic [3:0] CODE_EXTRC_LOW = 4'h5;
    localparam logic [3:0] CODE_INTRC_LOW = 4'h1;
    // three-bit crystal and two-bit other start-up codes
    localparam logic [2:0] XS_258_MAX = 3'h1;
    localparam logic [2:0] XS_1K_MAX = 3'h4;
    localparam logic [2:0] XS_NONE_A = 3'h2;
    localparam logic [2:0] XS_NONE_B = 3'h5;
    localparam logic [2:0] XS_SHORT_A = 3'h0;
    localparam logic [2:0] XS_SHORT_B = 3'h3;
    localparam logic [2:0] XS_SHORT_C = 3'h6;
    localparam logic [1:0] SUT_NONE = 2'h0;
    localparam logic [1:0] SUT_SHORT = 2'h1;
    // wake counts in selected-oscillator cycles
    localparam logic [16:0] WAKE_258 = 17'h00102;
    localparam logic [16:0] WAKE_1K = 17'h00400;
    localparam logic [16:0] WAKE_OTHER = 17'h00006;
    localparam int WAKE_16K = 16384;
    // watchdog oscillator time-outs
    localparam int WDT_SHORT = 4096;
    localparam int WDT_LONG = 65536;
    // register byte offsets
    localparam logic [11:0] OFS_FUSE = 12'h000;
    localparam logic [11:0] OFS_CTRL = 12'h004;
    localparam logic [11:0] OFS_STATUS = 12'h008;
    // fuse register fields
    localparam int F_CLKSRC_LSB = 0;
    localparam int F_STARTUP_LSB = 4;
    localparam int F_SWING_BIT = 6;
    // control register fields
    localparam int C_SLEEP_LSB = 0;
    localparam int C_ASYNC_BIT = 2;
    // status register fields
    localparam int S_STATE_LSB = 0;
    localparam int S_SRC_LSB = 4;
    localparam int S_RANGE_LSB = 8;
    localparam int S_SWING_BIT = 11;
    localparam int S_RUN_BIT = 12;
    typedef enum logic [2:0] {
        CSSS_SRC_XTAL = 3'h0,
        CSSS_SRC_LFXTAL = 3'h1,
        CSSS_SRC_EXTRC = 3'h2,
        CSSS_SRC_INTRC = 3'h3,
        CSSS_SRC_EXTCLK = 3'h4
    } csss_src_t;
    typedef enum logic [1:0] {
        CSSS_SLP_IDLE = 2'h0,
        CSSS_SLP_CONV = 2'h1,
        CSSS_SLP_PDOWN = 2'h2,
        CSSS_SLP_PSAVE = 2'h3
    } csss_sleep_t;
    typedef enum logic [2:0] {
        CSSS_ST_OSC = 3'h0,
        CSSS_ST_DLY = 3'h1,
        CSSS_ST_RUN = 3'h3,
        CSSS_ST_SLEEP = 3'h2,
        CSSS_ST_WAKE = 3'h6
    } csss_state_t;
endpackage : csss_pkg

// file: src/csss_top.sv
// clock source decode, start-up sequencing and clock-domain gating
// Function
// - clock-source code 1111..1010 is crystal, 1001 low-frequency crystal, 1000..0101 external RC, 0100..0001 internal RC, 0000 external clock.
// - each fuse bit reads one when unprogrammed and zero when programmed, and decoding uses that polarity.
// - on wake from power-down or power-save, start-up cycles of the selected oscillator are counted before execution resumes.
// - after reset a further delay follows the oscillator count, timed by the watchdog oscillator, except for start-up codes that select no delay.
// - the reset delay is either 4096 or 65536 watchdog oscillator cycles.
// - the fuses come up as clock source 0001 and start-up 10.
// - with the crystal selected, the upper three source bits give amplifier range 101, 110 or 111.
// - the amplifier runs full swing when the swing fuse is 0 and reduced swing when it is 1.
// - crystal code {source bit 0, start-up bits} 000-001 wakes in 258 cycles, 010-100 in 1K, 101-111 in 16K.
// - crystal codes 010 and 101 give no reset delay, 000/011/110 the short one, 001/100/111 the long one.
// - the asynchronous timer has its own clock domain that keeps running in sleep.
// - the converter has its own clock domain that runs while CPU and I/O clocks are gated in converter sleep mode.
// - the flash interface clock is gated together with the CPU clock.
`timescale 1ns/1ps
module csss_top #(
    parameter int WAKE_LONG_CYC = csss_pkg::WAKE_16K,
    parameter int WDT_SHORT_CYC = csss_pkg::WDT_SHORT,
    parameter int WDT_LONG_CYC = csss_pkg::WDT_LONG
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic OSC_TICK,
    input wire logic WDT_OSC_TICK,
    input wire logic WAKE_EVENT,
    input wire logic SLEEP_REQ,
    output logic RUN,
    output logic CPU_CLK_EN,
    output logic FLASH_CLK_EN,
    output logic IO_CLK_EN,
    output logic CONV_CLK_EN,
    output logic ASYNC_TIMER_CLK_EN,
    output logic [2:0] CLOCK_SOURCE,
    output logic [2:0] CRYSTAL_RANGE,
    output logic AMP_FULL_SWING
);
    localparam logic [16:0] WAKE_LONG = 17'(WAKE_LONG_CYC);
    localparam logic [16:0] WDT_SHORT_N = 17'(WDT_SHORT_CYC);
    localparam logic [16:0] WDT_LONG_N = 17'(WDT_LONG_CYC);

    ////////////////////////////////////////////////////////////////////////
    // reset release and input synchronisers
    logic [1:0] rst_pipe;
    logic rst_n;
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'h1};
        end
    end
    assign rst_n = rst_pipe[1];

    logic [2:0] osc_sync;
    logic [2:0] wdt_sync;
    logic [1:0] wake_sync;
    logic [2:0] next_osc_sync;
    logic [2:0] next_wdt_sync;
    logic [1:0] next_wake_sync;
    logic osc_edge;
    logic wdt_edge;
    always_comb begin
        next_osc_sync = {osc_sync[1:0], OSC_TICK};
        next_wdt_sync = {wdt_sync[1:0], WDT_OSC_TICK};
        next_wake_sync = {wake_sync[0], WAKE_EVENT};
    end
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            osc_sync <= 3'h0;
            wdt_sync <= 3'h0;
            wake_sync <= 2'h0;
        end else begin
            osc_sync <= next_osc_sync;
            wdt_sync <= next_wdt_sync;
            wake_sync <= next_wake_sync;
        end
    end
    // rising edges seen after the second stage only
    assign osc_edge = osc_sync[1] & ~osc_sync[2];
    assign wdt_edge = wdt_sync[1] & ~wdt_sync[2];

    ////////////////////////////////////////////////////////////////////////
    // register file
    logic [3:0] clock_source_select_fuses;
    logic [1:0] startup_time_fuses;
    logic amplifier_swing_option_fuse;
    logic [1:0] sleep_mode;
    logic async_enable;
    logic [31:0] rdata;
    logic slverr;
    logic [3:0] next_clksrc;
    logic [1:0] next_startup;
    logic next_swing;
    logic [1:0] next_sleep_mode;
    logic next_async_enable;
    logic [31:0] next_rdata;
    logic next_slverr;
    logic setup;
    logic access_wr;
    logic addr_hit;
    logic [31:0] status_word;
    csss_pkg::csss_state_t state;
    csss_pkg::csss_src_t src;
    logic [2:0] range_code;

    assign setup = PSEL & ~PENABLE;
    assign access_wr = PSEL & PENABLE & PWRITE;
    assign addr_hit = (PADDR == csss_pkg::OFS_FUSE)
        | (PADDR == csss_pkg::OFS_CTRL) | (PADDR == csss_pkg::OFS_STATUS);

    always_comb begin
        status_word = 32'h0;
        status_word[csss_pkg::S_STATE_LSB +: 3] = state;
        status_word[csss_pkg::S_SRC_LSB +: 3] = src;
        status_word[csss_pkg::S_RANGE_LSB +: 3] = range_code;
        status_word[csss_pkg::S_SWING_BIT] = AMP_FULL_SWING;
        status_word[csss_pkg::S_RUN_BIT] = RUN;
    end

    always_comb begin
        next_clksrc = clock_source_select_fuses;
        next_startup = startup_time_fuses;
        next_swing = amplifier_swing_option_fuse;
        next_sleep_mode = sleep_mode;
        next_async_enable = async_enable;
        next_rdata = rdata;
        next_slverr = slverr;
        if (setup) begin
            next_slverr = ~addr_hit;
            next_rdata = 32'h0;
            if (!PWRITE) begin
                unique case (PADDR)
                    csss_pkg::OFS_FUSE: begin
                        next_rdata[csss_pkg::F_CLKSRC_LSB +: 4] =
                            clock_source_select_fuses;
                        next_rdata[csss_pkg::F_STARTUP_LSB +: 2] =
                            startup_time_fuses;
                        next_rdata[csss_pkg::F_SWING_BIT] =
                            amplifier_swing_option_fuse;
                    end
                    csss_pkg::OFS_CTRL: begin
                        next_rdata[csss_pkg::C_SLEEP_LSB +: 2] = sleep_mode;
                        next_rdata[csss_pkg::C_ASYNC_BIT] = async_enable;
                    end
                    csss_pkg::OFS_STATUS: begin
                        next_rdata = status_word;
                    end
                    default: begin
                        next_rdata = 32'h0;
                    end
                endcase
            end
        end
        if (access_wr && PADDR == csss_pkg::OFS_FUSE) begin
            next_clksrc = PWDATA[csss_pkg::F_CLKSRC_LSB +: 4];
            next_startup = PWDATA[csss_pkg::F_STARTUP_LSB +: 2];
            next_swing = PWDATA[csss_pkg::F_SWING_BIT];
        end
        if (access_wr && PADDR == csss_pkg::OFS_CTRL) begin
            next_sleep_mode = PWDATA[csss_pkg::C_SLEEP_LSB +: 2];
            next_async_enable = PWDATA[csss_pkg::C_ASYNC_BIT];
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            clock_source_select_fuses <= csss_pkg::CLKSRC_DEFAULT;
            startup_time_fuses <= csss_pkg::STARTUP_DEFAULT;
            amplifier_swing_option_fuse <= csss_pkg::SWING_DEFAULT;
            sleep_mode <= csss_pkg::CSSS_SLP_IDLE;
            async_enable <= 1'h0;
            rdata <= 32'h0;
            slverr <= 1'h0;
        end else begin
            clock_source_select_fuses <= next_clksrc;
            startup_time_fuses <= next_startup;
            amplifier_swing_option_fuse <= next_swing;
            sleep_mode <= next_sleep_mode;
            async_enable <= next_async_enable;
            rdata <= next_rdata;
            slverr <= next_slverr;
        end
    end

    assign PREADY = 1'h1;
    assign PRDATA = rdata;
    assign PSLVERR = PSEL & PENABLE & slverr;

    ////////////////////////////////////////////////////////////////////////
    // fuse decode
    logic [2:0] xtal_code;
    logic [16:0] wake_count;
    logic [16:0] delay_count;
    logic delay_none;
    logic [2:0] crystal_range_select_fuses;
    logic crystal_startup_select_bit;

    assign crystal_range_select_fuses = clock_source_select_fuses[3:1];
    assign crystal_startup_select_bit = clock_source_select_fuses[0];
    assign xtal_code = {crystal_startup_select_bit, startup_time_fuses};

    always_comb begin
        if (clock_source_select_fuses >= csss_pkg::CODE_XTAL_LOW) begin
            src = csss_pkg::CSSS_SRC_XTAL;
        end else if (clock_source_select_fuses == csss_pkg::CODE_LFXTAL) begin
            src = csss_pkg::CSSS_SRC_LFXTAL;
        end else if (clock_source_select_fuses >= csss_pkg::CODE_EXTRC_LOW)
        begin
            src = csss_pkg::CSSS_SRC_EXTRC;
        end else if (clock_source_select_fuses >= csss_pkg::CODE_INTRC_LOW)
        begin
            src = csss_pkg::CSSS_SRC_INTRC;
        end else begin
            src = csss_pkg::CSSS_SRC_EXTCLK;
        end
    end

    always_comb begin
        range_code = 3'h0;
        if (src == csss_pkg::CSSS_SRC_XTAL) begin
            range_code = crystal_range_select_fuses;
        end
        wake_count = csss_pkg::WAKE_OTHER;
        delay_none = (startup_time_fuses == csss_pkg::SUT_NONE);
        delay_count = (startup_time_fuses == csss_pkg::SUT_SHORT)
            ? WDT_SHORT_N : WDT_LONG_N;
        if (src == csss_pkg::CSSS_SRC_LFXTAL) begin
            wake_count = csss_pkg::WAKE_1K;
            delay_none = 1'h0;
            delay_count = (startup_time_fuses == csss_pkg::SUT_NONE)
                ? WDT_SHORT_N : WDT_LONG_N;
        end
        if (src == csss_pkg::CSSS_SRC_XTAL) begin
            if (xtal_code <= csss_pkg::XS_258_MAX) begin
                wake_count = csss_pkg::WAKE_258;
            end else if (xtal_code <= csss_pkg::XS_1K_MAX) begin
                wake_count = csss_pkg::WAKE_1K;
            end else begin
                wake_count = WAKE_LONG;
            end
            delay_none = (xtal_code == csss_pkg::XS_NONE_A)
                | (xtal_code == csss_pkg::XS_NONE_B);
            if (xtal_code == csss_pkg::XS_SHORT_A
                || xtal_code == csss_pkg::XS_SHORT_B
                || xtal_code == csss_pkg::XS_SHORT_C) begin
                delay_count = WDT_SHORT_N;
            end else begin
                delay_count = WDT_LONG_N;
            end
        end
    end

    // programmed fuse (zero) gives the full swing
    assign AMP_FULL_SWING =
        (amplifier_swing_option_fuse == csss_pkg::FUSE_PROGRAMMED);
    assign CLOCK_SOURCE = src;
    assign CRYSTAL_RANGE = range_code;

    ////////////////////////////////////////////////////////////////////////
    // start-up sequencer
    csss_pkg::csss_state_t next_state;
    logic [16:0] count;
    logic [16:0] next_count;
    logic deep_sleep;

    assign deep_sleep = (sleep_mode == csss_pkg::CSSS_SLP_PDOWN)
        | (sleep_mode == csss_pkg::CSSS_SLP_PSAVE);

    always_comb begin
        next_state = state;
        next_count = count;
        unique case (state)
            csss_pkg::CSSS_ST_OSC: begin
                if (osc_edge) begin
                    next_count = count + 17'h1;
                end
                if (count >= wake_count) begin
                    next_count = 17'h0;
                    if (delay_none) begin
                        next_state = csss_pkg::CSSS_ST_RUN;
                    end else begin
                        next_state = csss_pkg::CSSS_ST_DLY;
                    end
                end
            end
            csss_pkg::CSSS_ST_DLY: begin
                if (wdt_edge) begin
                    next_count = count + 17'h1;
                end
                if (count >= delay_count) begin
                    next_count = 17'h0;
                    next_state = csss_pkg::CSSS_ST_RUN;
                end
            end
            csss_pkg::CSSS_ST_RUN: begin
                if (SLEEP_REQ) begin
                    next_state = csss_pkg::CSSS_ST_SLEEP;
                end
            end
            csss_pkg::CSSS_ST_SLEEP: begin
                if (wake_sync[1]) begin
                    next_count = 17'h0;
                    next_state = deep_sleep ? csss_pkg::CSSS_ST_WAKE
                        : csss_pkg::CSSS_ST_RUN;
                end
            end
            csss_pkg::CSSS_ST_WAKE: begin
                if (osc_edge) begin
                    next_count = count + 17'h1;
                end
                if (count >= wake_count) begin
                    next_count = 17'h0;
                    next_state = csss_pkg::CSSS_ST_RUN;
                end
            end
            default: begin
                next_count = 17'h0;
                next_state = csss_pkg::CSSS_ST_OSC;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state <= csss_pkg::CSSS_ST_OSC;
            count <= 17'h0;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock-domain enables
    logic run_q;
    logic cpu_q;
    logic io_q;
    logic conv_q;
    logic asy_q;
    logic next_run;
    logic next_cpu;
    logic next_io;
    logic next_conv;
    logic next_asy;

    always_comb begin
        next_run = (next_state == csss_pkg::CSSS_ST_RUN);
        next_cpu = next_run;
        next_io = next_run;
        next_conv = next_run;
        if (next_state == csss_pkg::CSSS_ST_SLEEP) begin
            next_io = (sleep_mode == csss_pkg::CSSS_SLP_IDLE);
            next_conv = (sleep_mode == csss_pkg::CSSS_SLP_IDLE)
                | (sleep_mode == csss_pkg::CSSS_SLP_CONV);
        end
        // async domain ignores sleep and start-up gating
        next_asy = async_enable;
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 1'h0;
            cpu_q <= 1'h0;
            io_q <= 1'h0;
            conv_q <= 1'h0;
            asy_q <= 1'h0;
        end else begin
            run_q <= next_run;
            cpu_q <= next_cpu;
            io_q <= next_io;
            conv_q <= next_conv;
            asy_q <= next_asy;
        end
    end

    assign RUN = run_q;
    assign CPU_CLK_EN = cpu_q;
    assign FLASH_CLK_EN = cpu_q;
    assign IO_CLK_EN = io_q;
    assign CONV_CLK_EN = conv_q;
    assign ASYNC_TIMER_CLK_EN = asy_q;
endmodule : csss_top

// file: testbench/clock_source_startup_select_bench.sv
// testbench: decode, apb access, reset delay and sleep/wake sequencing
`timescale 1ns/1ps
module clock_source_startup_select_bench;
    localparam int OSC_PER = 4;
    localparam int WDT_PER = 8;
    logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, wake_event = 1'b0, sleep_req = 1'b0, slow = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, osc_tick, wdt_tick, run, cpu_en, flash_en;
    logic io_en, conv_en, async_en, swing;
    logic [2:0] src, rng;
    int miscompares = 0;
    int n_tests = 0;
    always #12.5 clk = ~clk;
    csss_top #(.WAKE_LONG_CYC(20), .WDT_SHORT_CYC(8), .WDT_LONG_CYC(16))
    csss_top_inst (.CLK(clk), .RST_B(rst_b), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .OSC_TICK(osc_tick), .WDT_OSC_TICK(wdt_tick),
        .WAKE_EVENT(wake_event), .SLEEP_REQ(sleep_req), .RUN(run),
        .CPU_CLK_EN(cpu_en), .FLASH_CLK_EN(flash_en), .IO_CLK_EN(io_en),
        .CONV_CLK_EN(conv_en), .ASYNC_TIMER_CLK_EN(async_en),
        .CLOCK_SOURCE(src), .CRYSTAL_RANGE(rng), .AMP_FULL_SWING(swing));
    csss_osc_model csss_osc_model_inst (.slow(slow), .osc_tick(osc_tick),
        .wdt_tick(wdt_tick));
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("compares=%0d miscompares=%0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer; read data and error flag compared at the pready edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [31:0] exp,
                       input logic experr);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        chk(prdata, wr ? 32'h0 : exp);
        chk(32'(pslverr), 32'(experr));
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // reset, then time the start-up from release to execution
    task automatic do_reset;
        int n;
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (19) @(posedge clk);
        rst_b <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (run !== 1'b1);
        chk(32'(n >= 15 * WDT_PER + 5 * OSC_PER && n <= 200), 32'h1);
        apb(1'b0, csss_pkg::OFS_FUSE, 32'h0, 32'h61, 1'b0);
        chk(32'(src), 32'h3);
    endtask : do_reset
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end
    initial begin
        logic [3:0] c;
        logic [2:0] es;
        int n, lo, hi, per;
        do_reset();
        for (int i = 0; i < 16; i++) begin
            c = i[3:0];
            es = (c >= 4'hA) ? 3'h0 : (c == 4'h9) ? 3'h1 :
                 (c >= 4'h5) ? 3'h2 : (c >= 4'h1) ? 3'h3 : 3'h4;
            apb(1'b1, csss_pkg::OFS_FUSE, {25'h0, c[0], 2'h2, c}, 0, 0);
            @(negedge clk);
            chk(32'(src), 32'(es));
            chk(32'(rng), (c >= 4'hA) ? 32'(c[3:1]) : 32'h0);
            chk(32'(swing), {31'h0, ~c[0]});
        end
        apb(1'b0, 12'h00C, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 12'h010, 32'h5, 32'h0, 1'b1);
        apb(1'b1, csss_pkg::OFS_FUSE, 32'h5F, 32'h0, 1'b0);
        apb(1'b1, csss_pkg::OFS_STATUS, 32'h0, 32'h0, 1'b0);
        apb(1'b0, csss_pkg::OFS_STATUS, 32'h0, 32'h1703, 1'b0);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, csss_pkg::OFS_CTRL, 32'(4 + m), 32'h0, 1'b0);
            slow <= (m == 3);
            per = (m == 3) ? 2 * OSC_PER : OSC_PER;
            @(posedge clk);
            sleep_req <= 1'b1;
            @(posedge clk);
            sleep_req <= 1'b0;
            repeat (3) @(posedge clk);
            @(negedge clk);
            chk(32'({run, cpu_en, flash_en, io_en, conv_en, async_en}),
                32'({3'h0, m == 0, m <= 1, 1'b1}));
            @(posedge clk);
            wake_event <= 1'b1;
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (run !== 1'b1);
            wake_event <= 1'b0;
            lo = (m >= 2) ? 19 * per : 0;
            hi = (m >= 2) ? 23 * per : 8;
            chk(32'(n >= lo && n <= hi), 32'h1);
            @(negedge clk);
            chk(32'({cpu_en, flash_en}), 32'h3);
        end
        do_reset();
        tally_and_finish();
    end
endmodule : clock_source_startup_select_bench

// file: testbench/csss_checker.sv
// port-level assertions for the clock source and start-up selector
`timescale 1ns/1ps
module csss_checker #(
    parameter int WAKE_LONG_CYC = 16384,
    parameter int WDT_SHORT_CYC = 4096,
    parameter int WDT_LONG_CYC = 65536
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic OSC_TICK,
    input wire logic WDT_OSC_TICK,
    input wire logic WAKE_EVENT,
    input wire logic SLEEP_REQ,
    input wire logic RUN,
    input wire logic CPU_CLK_EN,
    input wire logic FLASH_CLK_EN,
    input wire logic IO_CLK_EN,
    input wire logic CONV_CLK_EN,
    input wire logic ASYNC_TIMER_CLK_EN,
    input wire logic [2:0] CLOCK_SOURCE,
    input wire logic [2:0] CRYSTAL_RANGE,
    input wire logic AMP_FULL_SWING
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [2:0] src_of(input logic [3:0] c);
        if (c >= csss_pkg::CODE_XTAL_LOW) return 3'h0;
        if (c == csss_pkg::CODE_LFXTAL) return 3'h1;
        if (c >= csss_pkg::CODE_EXTRC_LOW) return 3'h2;
        if (c >= csss_pkg::CODE_INTRC_LOW) return 3'h3;
        return 3'h4;
    endfunction : src_of
    function automatic int wake_of(input logic [6:0] f);
        logic [2:0] x;
        x = {f[0], f[5:4]};
        if (src_of(f[3:0]) == 3'h1) return 1024;
        if (src_of(f[3:0]) != 3'h0) return 6;
        if (x <= 3'h1) return 258;
        if (x <= 3'h4) return 1024;
        return WAKE_LONG_CYC;
    endfunction : wake_of
    function automatic int dly_of(input logic [6:0] f);
        logic [2:0] x;
        x = {f[0], f[5:4]};
        if (src_of(f[3:0]) == 3'h0) begin
            if (x == 3'h2 || x == 3'h5) return 0;
            return (x % 3 == 0) ? WDT_SHORT_CYC : WDT_LONG_CYC;
        end
        if (f[5:4] == 2'h0) return (f[3:0] == 4'h9) ? WDT_SHORT_CYC : 0;
        return (f[5:4] == 2'h1 && f[3:0] != 4'h9) ? WDT_SHORT_CYC
            : WDT_LONG_CYC;
    endfunction : dly_of
    ////////////////////////////////////////////////////////////////////////
    // shadow of fuse and control words, tick counts while halted
    logic wr;
    logic [6:0] fuse, next_fuse;
    logic [2:0] ctrl, next_ctrl;
    logic [16:0] osc_cnt, next_osc_cnt, wdt_cnt, next_wdt_cnt;
    logic osc_q, wdt_q, deep, next_deep, from_rst, next_from_rst;
    assign wr = PSEL && PENABLE && PREADY && PWRITE;
    always_comb begin
        next_fuse = fuse;
        next_ctrl = ctrl;
        if (wr && PADDR == csss_pkg::OFS_FUSE) next_fuse = PWDATA[6:0];
        if (wr && PADDR == csss_pkg::OFS_CTRL) next_ctrl = PWDATA[2:0];
        next_osc_cnt = RUN ? 17'h0 : osc_cnt + 17'(OSC_TICK && !osc_q);
        next_wdt_cnt = RUN ? 17'h0 : wdt_cnt + 17'(WDT_OSC_TICK && !wdt_q);
        next_deep = (RUN && SLEEP_REQ) ? ctrl[1] : deep;
        next_from_rst = from_rst && !RUN;
    end
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            fuse <= 7'h61;
            ctrl <= 3'h0;
            osc_cnt <= 17'h0;
            wdt_cnt <= 17'h0;
            osc_q <= 1'b0;
            wdt_q <= 1'b0;
            deep <= 1'b0;
            from_rst <= 1'b1;
        end else begin
            fuse <= next_fuse;
            ctrl <= next_ctrl;
            osc_cnt <= next_osc_cnt;
            wdt_cnt <= next_wdt_cnt;
            osc_q <= OSC_TICK;
            wdt_q <= WDT_OSC_TICK;
            deep <= next_deep;
            from_rst <= next_from_rst;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_flash_cpu;
        FLASH_CLK_EN == CPU_CLK_EN;
    endproperty
    a_flash_cpu: assert property (p_flash_cpu)
        else $error("flash enable differs from cpu enable");
    property p_src;
        CLOCK_SOURCE == src_of(fuse[3:0]);
    endproperty
    a_src: assert property (p_src)
        else $error("clock source decode wrong");
    property p_range;
        CRYSTAL_RANGE == ((fuse[3:0] >= 4'hA) ? fuse[3:1] : 3'h0);
    endproperty
    a_range: assert property (p_range)
        else $error("crystal range wrong");
    property p_swing;
        AMP_FULL_SWING == (fuse[6] == csss_pkg::FUSE_PROGRAMMED);
    endproperty
    a_swing: assert property (p_swing)
        else $error("amplifier swing wrong");
    property p_sleep;
        RUN && SLEEP_REQ |-> ##2 (!RUN && !CPU_CLK_EN);
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("execution not halted in sleep");
    property p_conv;
        RUN && SLEEP_REQ && ctrl[1:0] == csss_pkg::CSSS_SLP_CONV
            |-> ##2 (CONV_CLK_EN && !IO_CLK_EN);
    endproperty
    a_conv: assert property (p_conv)
        else $error("converter clock not kept alone");
    property p_async;
        RUN && SLEEP_REQ && ctrl[2] |-> ##2 ASYNC_TIMER_CLK_EN [*3];
    endproperty
    a_async: assert property (p_async)
        else $error("async timer clock stopped in sleep");
    property p_wake;
        $rose(RUN) && (deep || from_rst) |-> osc_cnt >= wake_of(fuse);
    endproperty
    a_wake: assert property (p_wake)
        else $error("ran before oscillator count done");
    property p_rdly;
        $rose(RUN) && from_rst |-> wdt_cnt >= dly_of(fuse);
    endproperty
    a_rdly: assert property (p_rdly)
        else $error("ran before watchdog delay done");
endmodule : csss_checker
bind csss_top csss_checker #(.WAKE_LONG_CYC(WAKE_LONG_CYC),
    .WDT_SHORT_CYC(WDT_SHORT_CYC), .WDT_LONG_CYC(WDT_LONG_CYC))
    csss_checker_inst (.CLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR, .OSC_TICK, .WDT_OSC_TICK,
    .WAKE_EVENT, .SLEEP_REQ, .RUN, .CPU_CLK_EN, .FLASH_CLK_EN, .IO_CLK_EN,
    .CONV_CLK_EN, .ASYNC_TIMER_CLK_EN, .CLOCK_SOURCE, .CRYSTAL_RANGE,
    .AMP_FULL_SWING);

// file: testbench/csss_osc_model.sv
// free-running system and watchdog oscillator pins
`timescale 1ns/1ps
module csss_osc_model (
    input wire logic slow,
    output logic osc_tick,
    output logic wdt_tick
);
    initial begin
        osc_tick = 1'b0;
        #7;
        forever begin
            #(slow ? 100 : 50);
            osc_tick = ~osc_tick;
        end
    end
    initial begin
        wdt_tick = 1'b0;
        #3;
        forever begin
            #100;
            wdt_tick = ~wdt_tick;
        end
    end
endmodule : csss_osc_model
